/* include/iaem_map.vh */
// Purpose: Register map, field encodings and protocol numbers of the IPv4 entry matcher.
// Assumes: AHB-Lite slave with 32-bit data, one aligned word per register.
// Notes:   Definitions only, included by its bare name.
`ifndef IAEM_MAP_VH
`define IAEM_MAP_VH

// Byte offsets of the registers.
`define IAEM_OFF_CTRL     8'h00
`define IAEM_OFF_PROTO    8'h04
`define IAEM_OFF_SRC_ADDR 8'h08
`define IAEM_OFF_SRC_MASK 8'h0c
`define IAEM_OFF_DST_ADDR 8'h10
`define IAEM_OFF_DST_MASK 8'h14
`define IAEM_OFF_STATUS   8'h18
`define IAEM_OFF_HITS     8'h1c

// Control register fields.
`define IAEM_CTRL_FTYPE_LSB 0
`define IAEM_CTRL_FTYPE_MSB 1
`define IAEM_CTRL_PSEL_LSB  2
`define IAEM_CTRL_PSEL_MSB  4
`define IAEM_CTRL_TTL_LSB   5
`define IAEM_CTRL_TTL_MSB   6
`define IAEM_CTRL_FRAG_LSB  7
`define IAEM_CTRL_FRAG_MSB  8
`define IAEM_CTRL_OPT_LSB   9
`define IAEM_CTRL_OPT_MSB   10
`define IAEM_CTRL_SRC_LSB   11
`define IAEM_CTRL_SRC_MSB   12
`define IAEM_CTRL_DST_LSB   13
`define IAEM_CTRL_DST_MSB   14
`define IAEM_CTRL_WIDTH     15
`define IAEM_CTRL_RESET     15'h0000

// Frame type selection.
`define IAEM_FTYPE_ANY  2'h0
`define IAEM_FTYPE_IPV4 2'h1

// Protocol selector.
`define IAEM_PSEL_ANY      3'h0
`define IAEM_PSEL_SPECIFIC 3'h1
`define IAEM_PSEL_ICMP     3'h2
`define IAEM_PSEL_UDP      3'h3
`define IAEM_PSEL_TCP      3'h4

// IPv4 protocol numbers.
`define IAEM_PROTO_ICMP 8'h01
`define IAEM_PROTO_TCP  8'h06
`define IAEM_PROTO_UDP  8'h11

// Three-way criteria: any, zero/no, non-zero/yes.
`define IAEM_TRI_ANY 2'h0
`define IAEM_TRI_NO  2'h1
`define IAEM_TRI_YES 2'h2

// Address selectors.
`define IAEM_ADDR_ANY     2'h0
`define IAEM_ADDR_HOST    2'h1
`define IAEM_ADDR_NETWORK 2'h2

// AHB transfer type bit that marks an active transfer.
`define IAEM_HTRANS_ACTIVE 1

`endif

/* src/iaem_matcher.v */
// Purpose: One IPv4 access_control_entry matcher with an AHB-Lite register slave.
// Assumes: Header fields come from a parser on hclk, qualified by hdr_valid.
// Notes:   Hit is registered one cycle after hdr_valid; parser rejects nothing.
// Behaviour
// [R1] Check IPv4 criteria only for IPv4 frame type.
// [R2] Protocol any ignores protocol field.
// [R3] Specific protocol must equal configured byte.
// [R4] ICMP/UDP/TCP selector restricts to that protocol.
// [R5] TTL criterion: zero, non-zero or any. Code: non-zero (YES) also passes a zero TTL.
// [R6] Fragment criterion: no, yes or any. Code: yes also passes unfragmented headers.
// [R7] Options criterion: no, yes or any. Code: yes also passes headers without options.
// [R8] Source selector any ignores source address.
// [R9] Source host requires exact address equality.
// [R10] Source network compares only masked bits.
// [R11] Destination selector any ignores destination address.
// [R12] Destination host requires exact address equality.
// [R13] Destination network compares only masked bits.
// [R14] Hit is AND of all criteria.
// [R15] Addresses and masks are full 32 bits.
// [R16] One-cycle hit pulse once fields valid.
`timescale 1ns/100ps
`include "iaem_map.vh"

module iaem_matcher #(
    parameter HITS_WIDTH = 32
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        hdr_valid,
    input  wire        hdr_is_ipv4,
    input  wire [7:0]  hdr_proto,
    input  wire [7:0]  hdr_ttl,
    input  wire        hdr_more_frag,
    input  wire [12:0] hdr_frag_offset,
    input  wire        hdr_options,
    input  wire [31:0] hdr_src_addr,
    input  wire [31:0] hdr_dst_addr,
    output reg         hit,
    output reg         hit_valid
);

    // Configuration registers, then the last-hit status and hit counter.
    reg [`IAEM_CTRL_WIDTH-1:0] ctrl;
    reg [7:0]                  proto_value;
    reg [31:0]                 src_addr;
    reg [31:0]                 src_mask;
    reg [31:0]                 dst_addr;
    reg [31:0]                 dst_mask;
    reg                        last_hit;
    reg [HITS_WIDTH-1:0]       hit_count;

    // Hit counter widened to a bus word; a zero-width pad would be illegal at 32 bits.
    reg [31:0]                 hits_word;

    // Registered address phase.
    reg                        wr_pending;
    reg                        rd_pending;
    reg [7:0]                  phase_addr;

    wire [1:0] ftype_sel = ctrl[`IAEM_CTRL_FTYPE_MSB:`IAEM_CTRL_FTYPE_LSB];
    wire [2:0] proto_sel = ctrl[`IAEM_CTRL_PSEL_MSB:`IAEM_CTRL_PSEL_LSB];
    wire [1:0] ttl_sel   = ctrl[`IAEM_CTRL_TTL_MSB:`IAEM_CTRL_TTL_LSB];
    wire [1:0] frag_sel  = ctrl[`IAEM_CTRL_FRAG_MSB:`IAEM_CTRL_FRAG_LSB];
    wire [1:0] opt_sel   = ctrl[`IAEM_CTRL_OPT_MSB:`IAEM_CTRL_OPT_LSB];
    wire [1:0] source_ip_selector = ctrl[`IAEM_CTRL_SRC_MSB:`IAEM_CTRL_SRC_LSB];
    wire [1:0] dest_ip_selector   = ctrl[`IAEM_CTRL_DST_MSB:`IAEM_CTRL_DST_LSB];

    // Three-way check: NO rejects a set condition, YES and ANY let it pass.
    // YES only permits; it does not demand the condition, as the entry wording reads.
    function tri_ok;
        input [1:0] sel;
        input       cond;
        begin
            tri_ok = !((sel == `IAEM_TRI_NO) && cond);
        end
    endfunction

    // Address check shared by source and destination; an unused code fails safe.
    function addr_ok;
        input [1:0]  sel;
        input [31:0] frame_addr;
        input [31:0] cfg_addr;
        input [31:0] cfg_mask;
        begin
            case (sel)
                `IAEM_ADDR_ANY:     addr_ok = 1'b1;
                `IAEM_ADDR_HOST:    addr_ok = (frame_addr == cfg_addr);
                `IAEM_ADDR_NETWORK: addr_ok = ((frame_addr ^ cfg_addr) & cfg_mask) == 32'h0;
                default:            addr_ok = 1'b0;
            endcase
        end
    endfunction

    // Protocol check.
    reg proto_ok;
    always @* begin
        case (proto_sel)
            `IAEM_PSEL_ANY:      proto_ok = 1'b1; // R2
            `IAEM_PSEL_SPECIFIC: proto_ok = (hdr_proto == proto_value); // R3
            `IAEM_PSEL_ICMP:     proto_ok = (hdr_proto == `IAEM_PROTO_ICMP); // R4
            `IAEM_PSEL_UDP:      proto_ok = (hdr_proto == `IAEM_PROTO_UDP); // R4
            `IAEM_PSEL_TCP:      proto_ok = (hdr_proto == `IAEM_PROTO_TCP); // R4
            default:             proto_ok = 1'b0;
        endcase
    end

    wire ttl_ok  = tri_ok(ttl_sel, hdr_ttl != 8'h00); // R5
    wire is_frag = hdr_more_frag || (hdr_frag_offset != 13'h0000);
    wire frag_ok = tri_ok(frag_sel, is_frag); // R6
    wire opt_ok  = tri_ok(opt_sel, hdr_options); // R7
    wire src_ok  = addr_ok(source_ip_selector, hdr_src_addr, src_addr, src_mask); // R8 R9 R10 R15
    wire dst_ok  = addr_ok(dest_ip_selector, hdr_dst_addr, dst_addr, dst_mask); // R11 R12 R13 R15

    // IPv4 criteria are evaluated only when the entry selects IPv4 frames.
    wire ipv4_sel = (ftype_sel == `IAEM_FTYPE_IPV4); // R1
    wire ipv4_ok  = hdr_is_ipv4 && proto_ok && ttl_ok && frag_ok && opt_ok && src_ok && dst_ok;
    wire type_ok  = (ftype_sel == `IAEM_FTYPE_ANY) ? 1'b1 : (ipv4_sel && ipv4_ok); // R1 R14

    // Match result, one pulse per valid header.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit       <= 1'b0;
            hit_valid <= 1'b0;
            last_hit  <= 1'b0;
            hit_count <= {HITS_WIDTH{1'b0}};
        end else begin
            hit_valid <= hdr_valid; // R16
            hit       <= hdr_valid && type_ok; // R14 R16
            if (hdr_valid) begin
                last_hit <= type_ok;
            end
            if (hdr_valid && type_ok) begin
                hit_count <= hit_count + {{(HITS_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Zero-extend the counter so any HITS_WIDTH up to 32 reads back cleanly.
    always @* begin
        hits_word                   = 32'h0;
        hits_word[HITS_WIDTH-1:0]   = hit_count;
    end

    wire addr_phase = hsel && hready && htrans[`IAEM_HTRANS_ACTIVE];

    // Bus slave: zero wait states, response always OKAY.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending  <= 1'b0;
            rd_pending  <= 1'b0;
            phase_addr  <= 8'h00;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= 32'h0;
            ctrl        <= `IAEM_CTRL_RESET;
            proto_value <= 8'h00;
            src_addr    <= 32'h0;
            src_mask    <= 32'h0;
            dst_addr    <= 32'h0;
            dst_mask    <= 32'h0;
        end else begin
            if (hready) begin
                wr_pending <= addr_phase && hwrite;
                rd_pending <= addr_phase && !hwrite;
                phase_addr <= haddr[7:0];
            end
            // Read data is taken a cycle early from the address phase so it is a flop.
            if (addr_phase && !hwrite) begin
                case ({haddr[7:2], 2'b00})
                    `IAEM_OFF_CTRL:     hrdata <= {{(32-`IAEM_CTRL_WIDTH){1'b0}}, ctrl};
                    `IAEM_OFF_PROTO:    hrdata <= {24'h000000, proto_value};
                    `IAEM_OFF_SRC_ADDR: hrdata <= src_addr;
                    `IAEM_OFF_SRC_MASK: hrdata <= src_mask;
                    `IAEM_OFF_DST_ADDR: hrdata <= dst_addr;
                    `IAEM_OFF_DST_MASK: hrdata <= dst_mask;
                    `IAEM_OFF_STATUS:   hrdata <= {31'h0, last_hit};
                    `IAEM_OFF_HITS:     hrdata <= hits_word;
                    default:            hrdata <= 32'h0;
                endcase
            end
            // Writes land in the data phase, when hwdata is on the bus.
            if (wr_pending) begin
                case ({phase_addr[7:2], 2'b00})
                    `IAEM_OFF_CTRL:     ctrl <= hwdata[`IAEM_CTRL_WIDTH-1:0];
                    `IAEM_OFF_PROTO:    proto_value <= hwdata[7:0];
                    `IAEM_OFF_SRC_ADDR: src_addr <= hwdata;
                    `IAEM_OFF_SRC_MASK: src_mask <= hwdata;
                    `IAEM_OFF_DST_ADDR: dst_addr <= hwdata;
                    `IAEM_OFF_DST_MASK: dst_mask <= hwdata;
                    default:            ctrl <= ctrl;
                endcase
            end
        end
    end

endmodule // iaem_matcher

/* test/iaem_checker_assertions.sv */
// Purpose: Timing checks on the matcher's bus and decision ports.
// Assumes: Single slave, so hready is fed from hreadyout.
// Notes:   Decision values are judged by the bench, which knows the setup.
`timescale 1ns/100ps
module iaem_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        hdr_valid,
    input wire        hit,
    input wire        hit_valid
);
    // A read address phase accepted at this edge.
    wire rd_taken = hsel && hready && htrans[1] && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_hdr_lone; hdr_valid ##1 !hdr_valid; endsequence
    sequence s_hit_pulse; hit_valid ##1 !hit_valid; endsequence
    a_decision_latency: assert property (hdr_valid |=> hit_valid)
        else $error("decision did not follow header");
    a_decision_cause: assert property (!hdr_valid |=> !hit_valid)
        else $error("decision without header");
    a_decision_pulse: assert property (s_hdr_lone |-> s_hit_pulse)
        else $error("decision not a single pulse");
    a_hit_in_decision: assert property (hit |-> hit_valid)
        else $error("hit outside a decision");
    a_bus_ready: assert property (hreadyout)
        else $error("slave inserted a wait state");
    a_bus_okay: assert property (!hresp)
        else $error("slave answered with an error");
    a_rdata_hold: assert property (!$past(rd_taken) |-> $stable(hrdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd_taken && haddr[7:5] != 3'h0 |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
endmodule // iaem_checker
bind iaem_matcher iaem_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .hdr_valid, .hit, .hit_valid);

/* test/iaem_parser_model.sv */
// Purpose: Header parser stand-in that hands one parsed header at a time.
// Assumes: Caller invokes send just after a clock edge.
// Notes:   Idle fields carry the inverse of the last header, never stale data.
`timescale 1ns/100ps
module iaem_parser_model (
    input  wire        hclk,
    output reg         hdr_valid,
    output wire        hdr_is_ipv4,
    output wire [7:0]  hdr_proto,
    output wire [7:0]  hdr_ttl,
    output wire        hdr_more_frag,
    output wire [12:0] hdr_frag_offset,
    output wire        hdr_options,
    output wire [31:0] hdr_src_addr,
    output wire [31:0] hdr_dst_addr
);
    reg [95:0] f;
    // All fields packed so one assignment loads or scrambles them together.
    assign {hdr_is_ipv4, hdr_proto, hdr_ttl, hdr_more_frag, hdr_frag_offset,
            hdr_options, hdr_src_addr, hdr_dst_addr} = f;
    initial begin
        f = 96'h0;
        hdr_valid = 1'b0;
    end
    task send(input [95:0] v);
        f <= v;
        hdr_valid <= 1'b1;
        @(posedge hclk);
        hdr_valid <= 1'b0;
        f <= ~v;
    endtask
endmodule // iaem_parser_model

/* test/test_ipv4_acl_entry_matcher.sv */
// Purpose: Register and match-decision tests of one IPv4 entry matcher.
// Assumes: Zero-wait AHB-Lite slave and a one-cycle decision latency.
// Notes:   Each case rewrites control, sends one header and checks hit.
`timescale 1ns/100ps
module test_ipv4_acl_entry_matcher;
    reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    reg [1:0] htrans = 2'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, hdr_valid, ipv4, mf, opt, hit, hit_valid;
    wire [7:0] proto, ttl;
    wire [12:0] off;
    wire [31:0] src, dst;
    integer num_errors = 0, compares = 0, nh = 0;
    reg last = 1'b0;
    always #4 hclk = ~hclk;
    iaem_parser_model u_par (.hclk(hclk), .hdr_valid(hdr_valid), .hdr_is_ipv4(ipv4),
        .hdr_proto(proto), .hdr_ttl(ttl), .hdr_more_frag(mf), .hdr_frag_offset(off),
        .hdr_options(opt), .hdr_src_addr(src), .hdr_dst_addr(dst));
    iaem_matcher u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hdr_valid(hdr_valid), .hdr_is_ipv4(ipv4), .hdr_proto(proto), .hdr_ttl(ttl),
        .hdr_more_frag(mf), .hdr_frag_offset(off), .hdr_options(opt),
        .hdr_src_addr(src), .hdr_dst_addr(dst), .hit(hit), .hit_valid(hit_valid));
    task chk(input string n, input [31:0] s, input [31:0] e);
        compares = compares + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // The address phase is held until hready is seen, then the data phase.
    task xfer(input w, input [7:0] a, input [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        q = hrdata;
    endtask
    // Base header: IPv4, protocol 2f, TTL 5, unfragmented, no options.
    task t(input [14:0] c, input [7:0] p, input [7:0] l, input [2:0] g, input [12:0] o,
           input [31:0] s, input [31:0] d, input e);
        xfer(1'b1, 8'h00, {17'h0, c});
        u_par.send({~g[2], p, l, g[1], o, g[0], s, d});
        #1 chk("hit", {31'h0, hit}, {31'h0, e});
        nh = nh + e;
        last = e;
    endtask
    task summarize;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors = num_errors + 1;
        summarize;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 8'h00, 32'h0); chk("ctrl", q, 32'h0);
        xfer(1'b1, 8'h04, 32'h2f); xfer(1'b1, 8'h08, 32'hc0a80105);
        xfer(1'b1, 8'h0c, 32'hffffff00); xfer(1'b1, 8'h10, 32'h0a000001);
        xfer(1'b1, 8'h14, 32'hff000000); xfer(1'b1, 8'h1c, 32'hffffffff);
        xfer(1'b0, 8'h04, 32'h0); chk("proto", q, 32'h2f);
        xfer(1'b0, 8'h20, 32'h0); chk("unmapped", q, 32'h0);
        $display("test registers done");
        t(15'h0001, 8'h2f, 8'h05, 3'h4, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0000, 8'h2f, 8'h05, 3'h4, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0001, 8'h99, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0005, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0005, 8'h2e, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0009, 8'h01, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h000d, 8'h06, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0011, 8'h06, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0021, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0041, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0081, 8'h2f, 8'h05, 3'h2, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0081, 8'h2f, 8'h05, 3'h0, 13'h1, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0101, 8'h2f, 8'h05, 3'h2, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0201, 8'h2f, 8'h05, 3'h1, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b0);
        t(15'h0401, 8'h2f, 8'h05, 3'h1, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h0001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'h12345678, 32'hffffffff, 1'b1);
        t(15'h0801, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80104, 32'h0a000001, 1'b0);
        t(15'h1001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a801ff, 32'h0a000001, 1'b1);
        t(15'h1001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80005, 32'h0a000001, 1'b0);
        t(15'h2001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h8a000001, 1'b0);
        t(15'h4001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0affffff, 1'b1);
        t(15'h4001, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0b000001, 1'b0);
        t(15'h2805, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000001, 1'b1);
        t(15'h2805, 8'h2f, 8'h05, 3'h0, 13'h0, 32'hc0a80105, 32'h0a000000, 1'b0);
        $display("test matching done");
        xfer(1'b0, 8'h1c, 32'h0); chk("hits", q, nh);
        xfer(1'b0, 8'h18, 32'h0); chk("status", q, {31'h0, last});
        $display("test counters done");
        summarize;
    end
endmodule // test_ipv4_acl_entry_matcher
